// File: logic/jcd_johnson_counter_divider.v
`timescale 1ns/1ps
`default_nettype none
`include "jcd_regs.vh"

// ==========================================================
// two-input decode gate, either input optionally inverted
module jcd_gate2 #(
  parameter INV_A = 0,
  parameter INV_B = 0
) (
  input wire a,
  input wire b,
  output wire y
);
  wire a_x = INV_A ? ~a : a;
  wire b_x = INV_B ? ~b : b;

  assign y = a_x & b_x;
endmodule

// ==========================================================
// generic Johnson ring with anti-lock and 2-input decode
module jcd_ring #(
  parameter N = 5
) (
  input wire clk,
  input wire rst,
  input wire clr,
  input wire adv,
  output reg [N-1:0] ring_q,
  output reg [2*N-1:0] dec_q,
  output reg carry_q
);
  reg [N-1:0] shift_d;
  reg [N-1:0] ring_d;
  wire [2*N-1:0] dec_d;
  wire carry_d;
  genvar g;

  // ========================================================
  // twisted shift: stage one takes the inverted last stage
  always @* begin
    shift_d = {ring_q[N-2:0], ~ring_q[N-1]};
    // a one may enter stage two only behind another one or
    // while the last stage is low; stray patterns such as
    // alternating bits then drain into the legal loop
    if (N > 2)
      shift_d[1] = ring_q[0] & (ring_q[1] | ~ring_q[N-1]);
  end

  // ========================================================
  // priority: clear, then hold, then count
  always @* begin
    if (clr)
      ring_d = {N{1'b0}};
    else if (!adv)
      ring_d = ring_q;
    else
      ring_d = shift_d;
  end

  // ========================================================
  // decode of the next state, two stage bits per output;
  // decoding the next state keeps outputs in step with the
  // ring, and the flip-flop behind each gate hides spikes
  generate
    for (g = 0; g < 2*N; g = g + 1) begin : gen_dec
      if (g == 0) begin : gen_zero
        jcd_gate2 #(.INV_A(1), .INV_B(1)) u_gate (
          .a(ring_d[N-1]),
          .b(ring_d[0]),
          .y(dec_d[g])
        );
      end else if (g < N) begin : gen_fill
        jcd_gate2 #(.INV_A(0), .INV_B(1)) u_gate (
          .a(ring_d[g-1]),
          .b(ring_d[g]),
          .y(dec_d[g])
        );
      end else if (g == N) begin : gen_full
        jcd_gate2 #(.INV_A(0), .INV_B(0)) u_gate (
          .a(ring_d[N-1]),
          .b(ring_d[0]),
          .y(dec_d[g])
        );
      end else begin : gen_drain
        jcd_gate2 #(.INV_A(1), .INV_B(0)) u_gate (
          .a(ring_d[g-N-1]),
          .b(ring_d[g-N]),
          .y(dec_d[g])
        );
      end
    end
  endgenerate

  // carry high for the first half of the count
  assign carry_d = ~ring_d[N-1];

  // ========================================================
  // state and registered outputs
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ring_q <= {N{1'b0}};
      dec_q <= {{(2*N-1){1'b0}}, 1'b1};
      carry_q <= 1'b1;
    end else begin
      ring_q <= ring_d;
      dec_q <= dec_d;
      carry_q <= carry_d;
    end
  end
endmodule

// ==========================================================
// top: three counter variants behind an APB slave
module jcd_johnson_counter_divider (
  input wire CLK_SYS,
  input wire RESET,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  output wire [9:0] DEC10_OUT,
  output wire DEC10_CARRY,
  output wire [7:0] DEC8_OUT,
  output wire DEC8_CARRY,
  output reg [4:0] STAGE_TAP
);
  localparam NP = `JCD_PRE_STAGES;
  reg [31:0] ctrl_q;
  reg [NP-1:0] jam_q;
  reg [NP-1:0] pre_d;
  reg data_in;
  reg fb_on;
  reg [NP-1:0] shift_pre;
  reg [31:0] rdata_d;
  reg rd_hit;
  reg wr_hit;

  // ========================================================
  // control fields and bus phases
  wire inh = ctrl_q[`JCD_CTRL_INH];
  wire sw_rst = ctrl_q[`JCD_CTRL_RST];
  wire pre_en = ctrl_q[`JCD_CTRL_PRE];
  wire [2:0] fsel = ctrl_q[`JCD_CTRL_FSEL_MSB:`JCD_CTRL_FSEL_LSB];
  wire setup = PSEL & ~PENABLE;
  wire wr = setup & PWRITE;
  wire [4:0] r10;
  wire [3:0] r8;

  // ========================================================
  // fixed rings
  jcd_ring #(.N(`JCD_DEC10_STAGES)) u_dec10 (
    .clk(CLK_SYS),
    .rst(RESET),
    .clr(sw_rst),
    .adv(~inh),
    .ring_q(r10),
    .dec_q(DEC10_OUT),
    .carry_q(DEC10_CARRY)
  );
  jcd_ring #(.N(`JCD_DEC8_STAGES)) u_dec8 (
    .clk(CLK_SYS),
    .rst(RESET),
    .clr(sw_rst),
    .adv(~inh),
    .ring_q(r8),
    .dec_q(DEC8_OUT),
    .carry_q(DEC8_CARRY)
  );

  // ========================================================
  // presettable ring; serial input from a selectable tap
  // fsel k (1..5) feeds stage k back inverted, a ratio of 2k;
  // fsel 0 holds the serial input low, so odd ratios and
  // longer chains are left to gating outside this block
  always @* begin
    fb_on = 1'b1;
    case (fsel)
      3'd1: data_in = ~STAGE_TAP[0];
      3'd2: data_in = ~STAGE_TAP[1];
      3'd3: data_in = ~STAGE_TAP[2];
      3'd4: data_in = ~STAGE_TAP[3];
      3'd5: data_in = ~STAGE_TAP[4];
      default: begin
        data_in = 1'b0;
        fb_on = 1'b0;
      end
    endcase
  end

  // ========================================================
  // shift path; anti-lock only while the ring is closed, so
  // an open ring shifts plainly for outside feedback
  always @* begin
    shift_pre = {STAGE_TAP[NP-2:0], data_in};
    if (fb_on)
      shift_pre[1] = STAGE_TAP[0] & (STAGE_TAP[1] | data_in);
  end

  // ========================================================
  // priority: clear, then jam, then count
  always @* begin
    if (sw_rst)
      pre_d = {NP{1'b0}};
    else if (pre_en)
      pre_d = jam_q;
    else
      pre_d = shift_pre;
  end

  always @(posedge CLK_SYS or posedge RESET) begin
    if (RESET)
      STAGE_TAP <= 5'h0;
    else
      STAGE_TAP <= pre_d;
  end

  // ========================================================
  // APB slave, zero wait states: each access is taken at its
  // setup edge and answered in the access cycle after it
  always @* begin
    rd_hit = 1'b1;
    case (PADDR)
      `JCD_CTRL_ADDR: rdata_d = ctrl_q;
      `JCD_JAM_ADDR: rdata_d = {27'h000_0000, jam_q};
      `JCD_DEC10_ADDR: rdata_d = {16'h0000, DEC10_CARRY, r10, DEC10_OUT};
      `JCD_DEC8_ADDR: rdata_d = {19'h0_0000, DEC8_CARRY, r8, DEC8_OUT};
      `JCD_STAGE_ADDR: rdata_d = {27'h000_0000, STAGE_TAP};
      default: begin
        rdata_d = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
    // only the two control words take writes
    wr_hit = (PADDR == `JCD_CTRL_ADDR) | (PADDR == `JCD_JAM_ADDR);
  end

  // ========================================================
  // write side
  always @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      ctrl_q <= `JCD_CTRL_RESET;
      jam_q <= {NP{1'b0}};
    end else if (wr) begin
      if (PADDR == `JCD_CTRL_ADDR)
        ctrl_q <= {25'h000_0000, PWDATA[6:0]};
      if (PADDR == `JCD_JAM_ADDR)
        jam_q <= PWDATA[NP-1:0];
    end
  end

  // ========================================================
  // response side; unmapped reads return zero with an error
  always @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= setup;
      PSLVERR <= setup & (PWRITE ? ~wr_hit : ~rd_hit);
      if (setup & ~PWRITE)
        PRDATA <= rdata_d;
    end
  end
endmodule
`default_nettype wire

// File: logic/jcd_regs.vh
`ifndef JCD_REGS_VH
`define JCD_REGS_VH
// ==========================================================
// register map (byte addresses)
`define JCD_CTRL_ADDR 12'h000
`define JCD_JAM_ADDR 12'h004
`define JCD_DEC10_ADDR 12'h008
`define JCD_DEC8_ADDR 12'h00C
`define JCD_STAGE_ADDR 12'h010
// ==========================================================
// ctrl fields
`define JCD_CTRL_INH 0
`define JCD_CTRL_RST 1
`define JCD_CTRL_PRE 2
`define JCD_CTRL_FSEL_LSB 4
`define JCD_CTRL_FSEL_MSB 6
`define JCD_CTRL_RESET 32'h0000_0000
// ==========================================================
// ring sizes
`define JCD_DEC10_STAGES 5
`define JCD_DEC8_STAGES 4
`define JCD_PRE_STAGES 5
`endif

// File: test/jcd_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// port checks
module jcd_sva (
  input wire CLK_SYS,
  input wire RESET,
  input wire PSEL,
  input wire PENABLE,
  input wire PREADY,
  input wire PSLVERR,
  input wire [9:0] DEC10_OUT,
  input wire DEC10_CARRY,
  input wire [7:0] DEC8_OUT,
  input wire DEC8_CARRY
);
  reg [9:0] p10_q;
  reg [7:0] p8_q;
  always @(posedge CLK_SYS) begin
    p10_q <= DEC10_OUT;
    p8_q <= DEC8_OUT;
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  sequence setup_s;
    PSEL && !PENABLE;
  endsequence
  hot_ten_a: assert property ($onehot(DEC10_OUT))
    else $error("decade decode not one-hot");
  hot_eight_a: assert property ($onehot(DEC8_OUT))
    else $error("octal decode not one-hot");
  carry_ten_a: assert property (DEC10_CARRY == |DEC10_OUT[4:0])
    else $error("decade carry wrong");
  carry_eight_a: assert property (DEC8_CARRY == |DEC8_OUT[3:0])
    else $error("octal carry wrong");
  step_ten_a: assert property (DEC10_OUT == p10_q
    || DEC10_OUT == {p10_q[8:0], p10_q[9]} || DEC10_OUT == 10'h001)
    else $error("decade step wrong");
  step_eight_a: assert property (DEC8_OUT == p8_q
    || DEC8_OUT == {p8_q[6:0], p8_q[7]} || DEC8_OUT == 8'h01)
    else $error("octal step wrong");
  bus_ready_a: assert property (setup_s |=> PREADY)
    else $error("no ready after setup");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready too long");
  err_ready_a: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
endmodule
bind jcd_johnson_counter_divider jcd_sva u_sva (.CLK_SYS, .RESET,
  .PSEL, .PENABLE, .PREADY, .PSLVERR, .DEC10_OUT, .DEC10_CARRY,
  .DEC8_OUT, .DEC8_CARRY);
`default_nettype wire

// File: test/jcd_chain.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// next stage, clocked straight from carry
module jcd_chain (
  input wire clk_in,
  input wire rst,
  output logic [7:0] cnt_q
);
  always @(posedge clk_in or posedge rst)
    if (rst) cnt_q <= 8'h00;
    else cnt_q <= cnt_q + 8'h01;
endmodule
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// bench
module tb_top;
  logic clk, rst, psel, pen, pwr, e;
  logic [11:0] pa;
  logic [31:0] pwd, rd;
  wire [31:0] prd;
  wire rdy, err, c10, c8;
  wire [9:0] d10;
  wire [7:0] d8, ch;
  wire [4:0] tap;
  logic [7:0] ch0;
  int errors, n_tests, cyc, c, k, n;
  jcd_johnson_counter_divider dut_u (.CLK_SYS(clk), .RESET(rst),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd),
    .PRDATA(prd), .PREADY(rdy), .PSLVERR(err), .DEC10_OUT(d10),
    .DEC10_CARRY(c10), .DEC8_OUT(d8), .DEC8_CARRY(c8), .STAGE_TAP(tap));
  jcd_chain u_ch (.clk_in(c10), .rst(rst), .cnt_q(ch));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = prd;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task summarize;
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    rst = 1'b1;
    {psel, pen, pwr, pa, pwd} = '0;
    repeat (8) @(posedge clk);
    chk(d10, 10'h001);
    rst <= 1'b0;
    apb(1, 12'h000, 32'h0000_0003);
    apb(1, 12'h000, 32'h0000_0001);
    apb(0, 12'h008, 0);
    chk(rd, 32'h0000_8001);
    ch0 = ch;
    for (k = 4; k < 14; k += 5) begin
      apb(1, 12'h000, 0);
      repeat (k) @(posedge clk);
      apb(1, 12'h000, 32'h0000_0001);
      c += 3 + k;
      repeat (4) @(posedge clk);
      chk(d10, 1 << c % 10);
      chk(d8, 1 << c % 8);
      chk({c10, c8}, {c % 10 < 5, c % 8 < 4});
      apb(0, 12'h008, 0);
      chk(rd[9:0], 1 << c % 10);
      apb(0, 12'h00C, 0);
      chk(rd[7:0], 1 << c % 8);
      chk(rd[12], c % 8 < 4);
    end
    chk(ch - ch0, 1);
    apb(0, 12'h014, 0);
    chk(e, 1);
    chk(rd, 0);
    apb(1, 12'h004, 32'h0000_0015);
    apb(1, 12'h000, 32'h0000_0004);
    repeat (2) @(posedge clk);
    chk(tap, 5'h15);
    apb(0, 12'h010, 0);
    chk(rd, 32'h0000_0015);
    apb(1, 12'h000, 32'h0000_0006);
    repeat (2) @(posedge clk);
    chk(tap, 0);
    for (k = 1; k <= 5; k++) begin
      apb(1, 12'h000, 32'h0000_0002);
      apb(1, 12'h000, k << 4);
      n = 0;
      while (tap[k-1] !== 1'b1) @(posedge clk);
      while (tap[k-1] === 1'b1) begin n++; @(posedge clk); end
      while (tap[k-1] === 1'b0) begin n++; @(posedge clk); end
      chk(n, 2 * k);
    end
    apb(1, 12'h000, 0);
    repeat (6) @(posedge clk);
    chk(tap, 0);
    summarize();
  end
endmodule
`default_nettype wire
